// >>> sas_adc_seq.sv
// converter sequencer top: registers, control fsm, pin sharing
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module sas_adc_seq
	import sas_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire sas_bus_t   bus_i,
	output logic [7:0]      rdata_o,
	input  wire logic       wait_i,
	input  wire logic       stop_i,
	input  wire logic       cmp_i,
	output sas_ana_t        ana_o,
	input  wire logic [3:0] pin_i,
	output logic [3:0]      pin_o,
	output logic [3:0]      pin_oe_n_o,
	output logic            irq_o,
	output logic            dma_req_o
);
	// ----------------------------------------------------------
	// declarations
	// ----------------------------------------------------------
	sas_state_t state_r;
	sas_state_t state_nxt;
	logic       done_flag_r;
	logic       irq_en_r;
	logic       cont_r;
	logic [4:0] chan_r;
	logic [7:0] data_r;
	logic [3:0] pdata_r;
	logic [3:0] pdir_r;
	logic       pend_r;
	logic       resume_r;
	logic       pwr_dn_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [7:0] div_r;
	logic       tick;
	logic       wr_ctrl;
	logic       rd_data;
	logic       new_on;
	logic       start;
	logic       done_raw;
	logic       done;
	logic       sample;
	logic [7:0] trial;
	logic [3:0] pin_rd;
	logic [3:0] pin_sel;

	// ----------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------
	assign wr_ctrl = bus_i.wr && bus_i.addr == SAS_OFF_CTRL;
	assign rd_data = bus_i.rd && bus_i.addr == SAS_OFF_DATA;
	assign new_on  = bus_i.wdata[4:0] != SAS_CH_OFF;
	assign pin_sel = sas_pin_hit(chan_r);
	// a completion counts only while still converting, so an
	// off-code write mid-conversion throws its result away
	assign done    = done_raw && state_r == SAS_CONV;

	// ----------------------------------------------------------
	// adc clock divider
	// ----------------------------------------------------------

	// free running so a start lands at any phase of the adc
	// clock; held in stop since the converter is inactive
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			div_r <= 8'h00;
		else if (stop_i || div_r == 8'(SAS_ADC_DIV - 1))
			div_r <= 8'h00;
		else
			div_r <= div_r + 8'h01;
	end

	assign tick = !stop_i && div_r == 8'(SAS_ADC_DIV - 1);

	// ----------------------------------------------------------
	// control state machine
	// ----------------------------------------------------------

	// wait_i is deliberately not an input here: the converter
	// runs on through wait mode
	always_comb begin
		state_nxt = state_r;
		start     = 1'b0;
		case (state_r)
			SAS_IDLE: begin
				if (stop_i)
					state_nxt = SAS_HALT;
				else if (wr_ctrl && new_on) begin
					state_nxt = SAS_CONV;
					start     = 1'b1;
				end
			end
			SAS_CONV: begin
				if (stop_i)
					state_nxt = SAS_HALT;
				else if (wr_ctrl) begin
					// any control register write abandons the conversion in flight
					state_nxt = new_on ? SAS_CONV : SAS_IDLE;
					start     = new_on;
				end else if (done) begin
					state_nxt = cont_r ? SAS_CONV : SAS_IDLE;
					start     = cont_r;
				end
			end
			SAS_HALT: begin
				// a write in the exit cycle overrides the saved intent
				if (!stop_i && (wr_ctrl ? new_on : resume_r)) begin
					state_nxt = SAS_CONV;
					start     = 1'b1;
				end else if (!stop_i)
					state_nxt = SAS_IDLE;
			end
			default: state_nxt = SAS_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			state_r <= SAS_IDLE;
		else
			state_r <= state_nxt;
	end

	// remember whether to pick up again once stop is left
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			resume_r <= 1'b0;
		else if (stop_i && wr_ctrl)
			resume_r <= new_on;
		else if (stop_i && state_r != SAS_HALT)
			resume_r <= (state_r == SAS_CONV || cont_r) &&
				chan_r != SAS_CH_OFF;
	end

	// ----------------------------------------------------------
	// status and control register
	// ----------------------------------------------------------

	// enable, continuous and channel fields
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_en_r <= SAS_CTRL_RST[SAS_BIT_IEN];
			cont_r   <= SAS_CTRL_RST[SAS_BIT_CONT];
			chan_r   <= SAS_CTRL_RST[4:0];
		end else if (wr_ctrl) begin
			irq_en_r <= bus_i.wdata[SAS_BIT_IEN];
			cont_r   <= bus_i.wdata[SAS_BIT_CONT];
			chan_r   <= bus_i.wdata[4:0];
		end
	end

	// done flag: a completion beats a clear in the same cycle;
	// with irq enabled the bit is only the request selector
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			done_flag_r <= SAS_CTRL_RST[SAS_BIT_DONE];
		else if (done && !irq_en_r)
			done_flag_r <= 1'b1;
		else if (wr_ctrl)
			done_flag_r <= bus_i.wdata[SAS_BIT_IEN] &&
				bus_i.wdata[SAS_BIT_DONE];
		else if (rd_data && !irq_en_r)
			done_flag_r <= 1'b0;
	end

	// pending request; set wins over clear
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pend_r <= 1'b0;
		else if (done && irq_en_r)
			pend_r <= 1'b1;
		else if (rd_data || wr_ctrl)
			pend_r <= 1'b0;
	end

	// not gated by wait_i, so it doubles as the wakeup source
	assign irq_o     = pend_r && !done_flag_r;
	assign dma_req_o = pend_r && done_flag_r;

	// ----------------------------------------------------------
	// result and port registers
	// ----------------------------------------------------------

	// overwritten each completion whether read or not
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			data_r <= SAS_ZERO8;
		else if (done)
			data_r <= trial;
	end

	// port latches always take writes; only the pin ignores them
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pdata_r <= SAS_PORT_RST;
			pdir_r  <= SAS_PORT_RST;
		end else if (bus_i.wr) begin
			if (bus_i.addr == SAS_OFF_PDATA)
				pdata_r <= bus_i.wdata[3:0];
			if (bus_i.addr == SAS_OFF_PDIR)
				pdir_r <= bus_i.wdata[3:0];
		end
	end

	// ----------------------------------------------------------
	// read path
	// ----------------------------------------------------------
	always_comb begin
		rdata_nxt = SAS_ZERO8;
		if (bus_i.rd) begin
			case (bus_i.addr)
				SAS_OFF_CTRL:
					rdata_nxt = {done_flag_r, irq_en_r, cont_r, chan_r};
				SAS_OFF_DATA:
					rdata_nxt = data_r;
				SAS_OFF_PDATA:
					rdata_nxt = {4'h0, pin_rd};
				SAS_OFF_PDIR:
					rdata_nxt = {4'h0, pdir_r};
				default:
					rdata_nxt = SAS_ZERO8;
			endcase
		end
	end

	// read data stand for exactly one cycle
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rdata_r <= SAS_ZERO8;
		else
			rdata_r <= rdata_nxt;
	end

	assign rdata_o = rdata_r;

	// ----------------------------------------------------------
	// analog front end drive
	// ----------------------------------------------------------

	// analog bias off for the off code and during stop
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pwr_dn_r <= 1'b1;
		else
			pwr_dn_r <= chan_r == SAS_CH_OFF || stop_i;
	end

	assign ana_o.chan       = chan_r;
	assign ana_o.power_down = pwr_dn_r;
	assign ana_o.sample     = sample;
	assign ana_o.trial      = trial;

	// ----------------------------------------------------------
	// submodules
	// ----------------------------------------------------------
	sas_sar_core u_sar (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.start_i   (start),
		.run_i     (state_r == SAS_CONV),
		.tick_i    (tick),
		.cmp_i     (cmp_i),
		.sample_o  (sample),
		.trial_o   (trial),
		.done_o    (done_raw)
	);

	sas_port_mux u_port (
		.clk_i      (clk_i),
		.reset_n_i  (reset_n_i),
		.sel_i      (pin_sel),
		.data_i     (pdata_r),
		.dir_i      (pdir_r),
		.pin_i      (pin_i),
		.pin_o      (pin_o),
		.pin_oe_n_o (pin_oe_n_o),
		.rd_o       (pin_rd)
	);

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------

	// cycles since the latest start, for the length check
	logic [12:0] conv_cnt_r;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			conv_cnt_r <= 13'h0000;
		else if (start)
			conv_cnt_r <= 13'h0000;
		else if (conv_cnt_r != 13'h1FFF)
			conv_cnt_r <= conv_cnt_r + 13'h0001;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_write_starts: assert property (
		wr_ctrl && new_on && !stop_i |=> state_r == SAS_CONV && sample)
		else $error("write did not start a conversion");
	a_conv_length: assert property (
		done |-> conv_cnt_r >= 13'(SAS_CLKS_MIN) &&
			conv_cnt_r <= 13'(SAS_CLKS_MAX + 1))
		else $error("conversion length out of range");
	a_result_load: assert property (
		done |=> data_r == $past(trial))
		else $error("result not rewritten");
	a_cont_rerun: assert property (
		done && cont_r && !stop_i && !wr_ctrl |=>
			state_r == SAS_CONV && sample)
		else $error("continuous mode did not rerun");
	a_single_idle: assert property (
		done && !cont_r && !stop_i && !wr_ctrl |=> state_r == SAS_IDLE)
		else $error("single mode did not idle");
	a_done_flag: assert property (
		done && !irq_en_r |=> done_flag_r ##1
			(done_flag_r || $past(rd_data || wr_ctrl)))
		else $error("done flag not held");
	a_irq_kind: assert property (
		done && irq_en_r |=> irq_o == !done_flag_r &&
			dma_req_o == done_flag_r)
		else $error("wrong request type raised");
	a_irq_clear: assert property (
		(rd_data || wr_ctrl) && !done |=> !irq_o && !dma_req_o)
		else $error("request not withdrawn");
	a_sel_only: assert property (
		irq_en_r && !wr_ctrl |=> done_flag_r == $past(done_flag_r))
		else $error("selector bit moved on its own");
	a_wait_runs: assert property (
		wait_i && state_r == SAS_CONV && !stop_i && !wr_ctrl && !done
			|=> state_r == SAS_CONV)
		else $error("conversion dropped during wait");
	a_stop_abort: assert property (
		stop_i |=> state_r == SAS_HALT && pwr_dn_r && !done)
		else $error("stop did not abort");
	a_power_off: assert property (
		chan_r == SAS_CH_OFF && !wr_ctrl && !stop_i &&
			state_r != SAS_HALT |=> state_r == SAS_IDLE)
		else $error("converter ran while powered off");

endmodule : sas_adc_seq

// >>> sas_pkg.sv
// shared constants and types for the sar adc sequencer
package sas_pkg;

	// ----------------------------------------------------------
	// register map and fields
	// ----------------------------------------------------------
	localparam logic [7:0] SAS_OFF_CTRL  = 8'h3C;
	localparam logic [7:0] SAS_OFF_DATA  = 8'h40;
	localparam logic [7:0] SAS_OFF_PDATA = 8'h44;
	localparam logic [7:0] SAS_OFF_PDIR  = 8'h48;
	localparam int         SAS_BIT_DONE  = 7;
	localparam int         SAS_BIT_IEN   = 6;
	localparam int         SAS_BIT_CONT  = 5;
	localparam logic [4:0] SAS_CH_OFF    = 5'h1F;
	localparam logic [7:0] SAS_CTRL_RST  = 8'h1F;
	localparam logic [7:0] SAS_ZERO8     = 8'h00;
	localparam logic [3:0] SAS_PORT_RST  = 4'h0;
	localparam logic [7:0] SAS_TRIAL_RST = 8'h80;

	// ----------------------------------------------------------
	// timing
	// ----------------------------------------------------------
	localparam int SAS_CLK_PERIOD_NS = 5;
	localparam int SAS_ADC_PERIOD_NS = 1000;
	localparam int SAS_ADC_DIV       =
		(SAS_ADC_PERIOD_NS + SAS_CLK_PERIOD_NS - 1) / SAS_CLK_PERIOD_NS;
	localparam int SAS_TICKS_MIN     = 16;
	localparam int SAS_TICKS_MAX     = 17;
	localparam int SAS_CLKS_MIN      = SAS_TICKS_MIN * SAS_ADC_DIV;
	localparam int SAS_CLKS_MAX      = SAS_TICKS_MAX * SAS_ADC_DIV;
	localparam logic [4:0] SAS_SAMPLE_TICK = 5'h01;
	localparam logic [4:0] SAS_LAST_TRIAL  = 5'h09;
	localparam logic [4:0] SAS_DONE_TICK   = 5'h11;

	// ----------------------------------------------------------
	// carriers and states
	// ----------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sas_bus_t;

	typedef struct packed {
		logic [4:0] chan;
		logic       power_down;
		logic       sample;
		logic [7:0] trial;
	} sas_ana_t;

	typedef enum logic [1:0] {
		SAS_IDLE = 2'b00,
		SAS_CONV = 2'b01,
		SAS_HALT = 2'b10
	} sas_state_t;

	// one-hot port pin taken by a channel code, zero for others
	function automatic logic [3:0] sas_pin_hit(input logic [4:0] ch);
		sas_pin_hit = (ch[4:2] == 3'b000) ? (4'h1 << ch[1:0]) : 4'h0;
	endfunction : sas_pin_hit

endpackage : sas_pkg

// >>> sas_sar_core.sv
// successive approximation engine with tick-based sequencing
`timescale 1ns/100ps
module sas_sar_core
	import sas_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       start_i,
	input  wire logic       run_i,
	input  wire logic       tick_i,
	input  wire logic       cmp_i,
	output logic            sample_o,
	output logic [7:0]      trial_o,
	output logic            done_o
);
	logic [4:0] tcnt_r;
	logic [4:0] tcnt_nxt;
	logic       sample_r;
	logic       done_r;
	logic [7:0] trial_r;

	assign tcnt_nxt = tcnt_r + 5'h01;
	assign sample_o = sample_r;
	assign trial_o  = trial_r;
	assign done_o   = done_r;

	// tick counter, cleared by a fresh start or when not running
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			tcnt_r <= 5'h00;
		else if (start_i || !run_i)
			tcnt_r <= 5'h00;
		else if (tick_i)
			tcnt_r <= tcnt_nxt;
	end

	// sampling window spans the first adc clock
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			sample_r <= 1'b0;
		else if (start_i)
			sample_r <= 1'b1;
		else if (!run_i || (tick_i && tcnt_nxt == SAS_SAMPLE_TICK))
			sample_r <= 1'b0;
	end

	// one bit judged per tick, msb first; input above the
	// reference keeps every bit so the code saturates at FF
	for (genvar b = 0; b < 8; b++) begin : g_bit
		localparam logic [4:0] JUDGE = SAS_LAST_TRIAL - 5'(b);
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i)
				trial_r[b] <= SAS_TRIAL_RST[b];
			else if (start_i)
				trial_r[b] <= SAS_TRIAL_RST[b];
			else if (run_i && tick_i) begin
				if (tcnt_nxt == JUDGE)
					trial_r[b] <= cmp_i;
				else if (tcnt_nxt == JUDGE - 5'h01)
					trial_r[b] <= 1'b1;
			end
		end
	end

	// completion on the 17th tick; free divider phase gives 16..17
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			done_r <= 1'b0;
		else
			done_r <= run_i && !start_i && tick_i &&
				(tcnt_nxt == SAS_DONE_TICK);
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_start_msb: assert property (
		start_i |=> sample_o && trial_o == SAS_TRIAL_RST)
		else $error("trial did not begin at midscale");
	a_done_count: assert property (
		done_o |-> tcnt_r == SAS_DONE_TICK && !sample_o)
		else $error("done without full tick count");

endmodule : sas_sar_core

// >>> sas_port_mux.sv
// shared port pin override and readback for the converter
`timescale 1ns/100ps
module sas_port_mux
	import sas_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic [3:0] sel_i,
	input  wire logic [3:0] data_i,
	input  wire logic [3:0] dir_i,
	input  wire logic [3:0] pin_i,
	output logic [3:0]      pin_o,
	output logic [3:0]      pin_oe_n_o,
	output logic [3:0]      rd_o
);
	// pin drivers are registered so the pads never glitch
	for (genvar p = 0; p < 4; p++) begin : g_pin
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				pin_o[p]      <= 1'b0;
				pin_oe_n_o[p] <= 1'b1;
			end else begin
				pin_o[p]      <= data_i[p];
				pin_oe_n_o[p] <= !(dir_i[p] && !sel_i[p]);
			end
		end

		// converter pin never shows its noisy analog level
		always_comb begin
			if (sel_i[p])
				rd_o[p] = dir_i[p] & data_i[p];
			else
				rd_o[p] = dir_i[p] ? data_i[p] : pin_i[p];
		end

		a_pin_release: assert property (
			@(posedge clk_i) disable iff (!reset_n_i)
			sel_i[p] |=> pin_oe_n_o[p])
			else $error("selected pin still driven");
	end

endmodule : sas_port_mux

// >>> sas_ana_model.sv
// analog front end model: channel mux and comparator for the sequencer
`timescale 1ns/100ps
module sas_ana_model
	import sas_pkg::*;
(
	input  wire logic              clk_i,
	input  wire sas_ana_t          ana_i,
	input  wire logic signed [9:0] lvl_i [4],
	output logic                   cmp_o
);
	logic signed [9:0] vin;
	logic              known;
	logic              junk_r = 1'b0;

	// meaningless answer toggles so no stale level can pass for a result
	always_ff @(posedge clk_i) begin
		junk_r <= ~junk_r;
	end

	// ----------------------------------------------------------
	// input selection
	// ----------------------------------------------------------
	// one source per input code 00..03, references on the top codes
	always_comb begin
		known = 1'b1;
		case (ana_i.chan)
			5'h00, 5'h01, 5'h02, 5'h03: vin = lvl_i[ana_i.chan[1:0]];
			5'h1D: vin = 10'sh0FF;
			5'h1E: vin = 10'sh000;
			default: begin
				vin   = 10'sh000;
				known = 1'b0;
			end
		endcase
	end

	// levels beyond the references saturate through the compare itself
	assign cmp_o = (ana_i.power_down || !known) ? junk_r :
		(vin >= $signed({2'b00, ana_i.trial}));
endmodule : sas_ana_model

// >>> tb_sas_adc_seq.sv
// self-checking testbench for the converter sequencer
`timescale 1ns/100ps
module tb_sas_adc_seq
	import sas_pkg::*;
;
	logic              clk_i = 1'b0;
	logic              reset_n_i = 1'b0;
	sas_bus_t          bus;
	logic [7:0]        rdata;
	logic              wait_i, stop_i, cmp, irq, dma;
	sas_ana_t          ana;
	logic [3:0]        pin_i, pin_o, pin_oe_n;
	logic signed [9:0] lvl [4];
	logic              samp_q = 1'b0;
	logic [7:0]        d;
	int                errors = 0;
	int                compares = 0;
	int                samples = 0;
	int                n, m;
	int                lo = SAS_CLKS_MIN - 4;
	int                hi = SAS_CLKS_MAX + 8;
	logic [4:0]        chans [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1D, 5'h1E};
	logic [7:0]        exps [6] = '{8'h5A, 8'hA5, 8'hFF, 8'h00, 8'hFF, 8'h00};

	always #2.5 clk_i = ~clk_i;

	// released pins sit at their pull-up level
	assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & 4'hF);

	// count conversion starts seen on the analog side
	always @(posedge clk_i) begin
		samp_q <= ana.sample;
		if (ana.sample && !samp_q)
			samples++;
	end

	sas_adc_seq dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus),
		.rdata_o(rdata), .wait_i(wait_i), .stop_i(stop_i), .cmp_i(cmp),
		.ana_o(ana), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n),
		.irq_o(irq), .dma_req_o(dma));
	sas_ana_model model (.clk_i(clk_i), .ana_i(ana), .lvl_i(lvl),
		.cmp_o(cmp));

	// ----------------------------------------------------------
	// bus and check tasks
	// ----------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i);
		bus.addr  <= a;
		bus.wdata <= v;
		bus.wr    <= 1'b1;
		@(posedge clk_i);
		bus.wr    <= 1'b0;
	endtask : wr

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_i);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge clk_i);
		bus.rd   <= 1'b0;
		@(negedge clk_i);
		v = rdata;
	endtask : rd

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("mismatch t=%0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic chk_rng(input int g, input int l, input int h);
		compares++;
		if (g < l || g > h) begin
			errors++;
			$display("mismatch t=%0t count %0d not in %0d..%0d", $time, g, l, h);
		end
	endtask : chk_rng

	task automatic idle(input int c);
		repeat (c) @(posedge clk_i);
	endtask : idle

	// polls the flag, or the request lines when interrupts are on
	task automatic wait_conv(input bit by_req, output int k);
		logic [7:0] v;
		bit         got;
		k   = 0;
		got = 0;
		while (!got && k < 4000) begin
			if (by_req) begin
				@(negedge clk_i);
				k++;
				got = (irq === 1'b1) || (dma === 1'b1);
			end else begin
				rd(SAS_OFF_CTRL, v);
				k  += 2;
				got = (v[SAS_BIT_DONE] === 1'b1);
			end
		end
	endtask : wait_conv

	task automatic complete_run();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	// a hang counts against the run
	initial begin
		idle(80000);
		errors++;
		$display("mismatch t=%0t watchdog expired", $time);
		complete_run();
	end

	// ----------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------
	initial begin
		bus    = '0;
		wait_i = 1'b0;
		stop_i = 1'b0;
		lvl    = '{10'sd90, 10'sd165, 10'sd300, -10'sd5};
		idle(8);
		reset_n_i <= 1'b1;
		@(negedge clk_i);
		chk({7'h00, ana.power_down}, 8'h01);
		rd(SAS_OFF_CTRL, d);
		chk(d, SAS_CTRL_RST);
		wr(8'h50, 8'hFF);
		rd(8'h50, d);
		chk(d, SAS_ZERO8);
		chk_rng(samples, 0, 0);
		// every input and reference channel code, with the cpu parked in wait
		@(posedge clk_i);
		wait_i <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			wr(SAS_OFF_CTRL, {3'b000, chans[i]});
			wait_conv(0, n);
			chk_rng(n, lo, hi);
			rd(SAS_OFF_DATA, d);
			chk(d, exps[i]);
			rd(SAS_OFF_CTRL, d);
			chk({7'h00, d[SAS_BIT_DONE]}, 8'h00);
		end
		m = samples;
		idle(3600);
		chk_rng(samples, m, m);
		// continuous runs overwrite the unread result
		wr(SAS_OFF_CTRL, 8'h20);
		wait_conv(0, n);
		lvl[0] = 10'sd51;
		idle(3500);
		rd(SAS_OFF_DATA, d);
		chk(d, 8'h33);
		m = samples;
		idle(3500);
		chk_rng(samples, m + 1, m + 2);
		wr(SAS_OFF_CTRL, 8'h00);
		wait_conv(0, n);
		m = samples;
		idle(3600);
		chk_rng(samples, m, m);
		// completion requests, cpu then dma selector
		wr(SAS_OFF_CTRL, 8'h40);
		wait_conv(1, n);
		chk({6'h00, irq, dma}, 8'h02);
		@(posedge clk_i);
		wait_i <= 1'b0;
		rd(SAS_OFF_DATA, d);
		chk({7'h00, irq}, 8'h00);
		wr(SAS_OFF_CTRL, 8'hC0);
		rd(SAS_OFF_CTRL, d);
		chk(d, 8'hC0);
		wait_conv(1, n);
		chk({6'h00, irq, dma}, 8'h01);
		wr(SAS_OFF_CTRL, 8'h1F);
		@(negedge clk_i);
		chk({7'h00, dma}, 8'h00);
		// a write mid-conversion restarts on the new channel
		wr(SAS_OFF_CTRL, 8'h01);
		idle(2000);
		wr(SAS_OFF_CTRL, 8'h02);
		wait_conv(0, n);
		chk_rng(n, lo, hi);
		rd(SAS_OFF_DATA, d);
		chk(d, 8'hFF);
		// stop abandons the conversion and resumes afterwards
		wr(SAS_OFF_CTRL, 8'h00);
		idle(1000);
		stop_i <= 1'b1;
		idle(3);
		@(negedge clk_i);
		chk({7'h00, ana.power_down}, 8'h01);
		idle(3000);
		rd(SAS_OFF_CTRL, d);
		chk({7'h00, d[SAS_BIT_DONE]}, 8'h00);
		@(posedge clk_i);
		stop_i <= 1'b0;
		wait_conv(0, n);
		chk_rng(n, lo, hi);
		rd(SAS_OFF_DATA, d);
		chk(d, 8'h33);
		// selected pin is taken from the port, the rest stay ordinary
		wr(SAS_OFF_PDATA, 8'h0A);
		wr(SAS_OFF_PDIR, 8'h0F);
		wr(SAS_OFF_CTRL, 8'h01);
		idle(2);
		@(negedge clk_i);
		chk({4'h0, pin_oe_n}, 8'h02);
		chk({4'h0, pin_o}, 8'h0A);
		rd(SAS_OFF_PDATA, d);
		chk({7'h00, d[1]}, 8'h01);
		wr(SAS_OFF_PDIR, 8'h0D);
		rd(SAS_OFF_PDATA, d);
		chk({7'h00, d[1]}, 8'h00);
		chk(d, 8'h08);
		wr(SAS_OFF_CTRL, 8'h02);
		idle(2);
		@(negedge clk_i);
		chk({4'h0, pin_oe_n}, 8'h06);
		wr(SAS_OFF_CTRL, 8'h1F);
		complete_run();
	end
endmodule : tb_sas_adc_seq
